// ==== core/lcp_line_ctl.sv ====
// Line control and polarity configuration core with AHB-Lite registers.
// Assumes a single 20 MHz clock and synchronous line indications.
//
// What this block does
// - Sense receive polarity continuously, always.
// - Correction enabled: invert reversed receive data.
// - Correction disabled: never invert receive data.
// - Polarity flag shows true polarity, unaffected by writes.
// - No EEPROM: configuration resets to 0x0013.
// - EEPROM present: may load initial configuration.
// - Bit 8 attach port, bit 9 auto, else pair.
// - Pair transmitter idle without link or test-disable.
// - Receive disable finishes current frame, blocks next.
// - Transmit disable finishes current frame, blocks next.
//
// Implementation choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
module lcp_line_ctl (
    // Clock and reset
    input  wire logic          mclk,
    input  wire logic          sys_rst,
    // AHB-Lite slave
    input  wire logic          hsel,
    input  wire logic [11:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [31:0]   hwdata,
    input  wire logic          hready,
    output var  logic          hreadyout,
    output var  logic [31:0]   hrdata,
    output var  logic          hresp,
    // Configuration EEPROM loader
    input  wire logic          ee_present,
    input  wire logic          ee_load_valid,
    input  wire logic [15:0]   ee_load_data,
    // Twisted-pair receive line
    input  wire logic          tp_pulse_pos,
    input  wire logic          tp_pulse_neg,
    input  wire logic          tp_rx_data,
    input  wire logic          link_ok,
    output var  logic          rx_data,
    // Receive frame control
    input  wire logic          crs,
    output var  logic          rx_accept,
    // Transmit frame control
    input  wire logic          tx_request,
    input  wire logic          tx_done,
    output var  logic          tx_active,
    // Port and MAC options
    output var  logic          aui_select,
    output var  logic          tp_select,
    output var  logic          tp_tx_enable,
    output var  logic          two_part_deferral,
    output var  logic          modified_backoff_enable,
    output var  logic          low_squelch_select
);
    import lcp_pkg::*;

    // ==========================================================
    // State machine types
    typedef enum logic [1:0] {
        LCP_RX_IDLE = 2'b00,   // Waiting for a frame
        LCP_RX_PASS = 2'b01,   // Frame accepted
        LCP_RX_DROP = 2'b10    // Frame refused, wait for its end
    } lcp_rx_state_t;

    typedef enum logic [0:0] {
        LCP_TX_IDLE = 1'b0,    // No transmission
        LCP_TX_SEND = 1'b1     // Frame in progress
    } lcp_tx_state_t;

    // ==========================================================
    // Polarity detector
    lcp_pol_if pol_bus ();
    assign pol_bus.pulse_pos = tp_pulse_pos;
    assign pol_bus.pulse_neg = tp_pulse_neg;

    lcp_pol_detect u_pol (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .pol     (pol_bus)
    );

    // ==========================================================
    // Register state
    logic [15:0] line_config;        // Line configuration register
    logic [15:0] next_line_config;
    logic [15:0] link_ctl;           // Link test control register
    logic [15:0] next_link_ctl;
    logic        ee_pending;         // EEPROM load window open
    logic        next_ee_pending;
    logic        boot_seen;          // First cycle after reset passed
    logic        next_boot_seen;
    logic        wr_pend;            // Write data phase pending
    logic        next_wr_pend;
    logic [11:0] wr_addr;            // Address of pending write
    logic [11:0] next_wr_addr;
    logic [31:0] next_hrdata;
    logic [15:0] line_state;         // Live status word

    // Decoded configuration
    logic polarity_fix_disable;
    logic receive_enable_ctl;
    logic transmit_enable_ctl;
    logic attach_port_force;
    logic port_auto_select;
    logic link_test_disable;
    logic polarity_normal_flag;

    assign polarity_fix_disable = line_config[LCP_CFG_POL_DIS];
    assign receive_enable_ctl   = line_config[LCP_CFG_RX_ON];
    assign transmit_enable_ctl  = line_config[LCP_CFG_TX_ON];
    assign attach_port_force    = line_config[LCP_CFG_AUI_ONLY];
    assign port_auto_select     = line_config[LCP_CFG_AUTO_SEL];
    assign link_test_disable    = link_ctl[LCP_LINK_TEST_DIS];
    // Taken from the detector only, so no write can touch it
    assign polarity_normal_flag = !pol_bus.reversed;

    // Address phase accepted
    logic ahb_take;
    assign ahb_take = hsel && hready
                      && (htrans == LCP_HTRANS_NONSEQ || htrans == LCP_HTRANS_SEQ);

    // Status word assembled from live state
    always_comb begin
        line_state                 = LCP_ST_ID;
        line_state[LCP_ST_LINK_OK] = link_ok;
        line_state[LCP_ST_AUI]     = aui_select;
        line_state[LCP_ST_TP]      = tp_select;
        line_state[LCP_ST_POL_OK]  = polarity_normal_flag;
        line_state[LCP_ST_CRS]     = crs;
    end

    // ==========================================================
    // Register file next values
    // Read data is formed from the next register values so that a read
    // right behind a write to the same word returns the new contents.
    always_comb begin
        next_line_config = line_config;
        next_link_ctl    = link_ctl;
        next_ee_pending  = ee_pending;
        next_boot_seen   = 1'b1;
        next_wr_pend     = ahb_take && hwrite;
        next_wr_addr     = ahb_take ? haddr : wr_addr;
        next_hrdata      = hrdata;
        // Open the load window once, just after reset release
        if (!boot_seen) begin
            next_ee_pending = ee_present;
        end else if (ee_pending && !ee_present) begin
            // EEPROM vanished: keep the fixed default
            next_ee_pending = 1'b0;
        end else if (ee_pending && ee_load_valid) begin
            // Writable fields from the EEPROM, identifier bits kept
            next_line_config = (ee_load_data & LCP_CFG_WMASK)
                               | (LCP_CFG_RESET & ~LCP_CFG_WMASK);
            next_ee_pending  = 1'b0;
        end
        // Host write completes in its data phase
        if (wr_pend && hready) begin
            if (wr_addr == LCP_OFS_LINE_CONFIG) begin
                // Polarity flag is not stored here, writes cannot reach it
                next_line_config = (hwdata[15:0] & LCP_CFG_WMASK)
                                   | (line_config & ~LCP_CFG_WMASK);
                next_ee_pending  = 1'b0;
            end else if (wr_addr == LCP_OFS_LINK_CTL) begin
                next_link_ctl = {15'h0000, hwdata[LCP_LINK_TEST_DIS]};
            end
        end
        // Read data for the coming data phase
        if (ahb_take && !hwrite) begin
            if (haddr == LCP_OFS_LINE_CONFIG) begin
                next_hrdata = {16'h0000, next_line_config};
            end else if (haddr == LCP_OFS_LINE_STATE) begin
                next_hrdata = {16'h0000, line_state};
            end else if (haddr == LCP_OFS_LINK_CTL) begin
                next_hrdata = {16'h0000, next_link_ctl};
            end else begin
                // Unmapped words read as zero
                next_hrdata = 32'h0000_0000;
            end
        end
    end

    // Register only
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            line_config <= LCP_CFG_RESET;
            link_ctl    <= LCP_LINK_RESET;
            ee_pending  <= 1'b0;
            boot_seen   <= 1'b0;
            wr_pend     <= 1'b0;
            wr_addr     <= 12'h000;
            hrdata      <= 32'h0000_0000;
            hreadyout   <= 1'b0;
            hresp       <= 1'b0;
        end else begin
            line_config <= next_line_config;
            link_ctl    <= next_link_ctl;
            ee_pending  <= next_ee_pending;
            boot_seen   <= next_boot_seen;
            wr_pend     <= next_wr_pend;
            wr_addr     <= next_wr_addr;
            hrdata      <= next_hrdata;
            // Zero wait states; always OKAY
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
        end
    end

    // ==========================================================
    // Receive polarity correction and port selection next values
    logic next_rx_data;
    logic next_aui_select;
    logic next_tp_select;
    logic next_tp_tx_enable;

    always_comb begin
        // Invert only when reversed and correction allowed
        if (!polarity_fix_disable) begin
            next_rx_data = tp_rx_data ^ pol_bus.reversed;
        end else begin
            next_rx_data = tp_rx_data;
        end
        // Port choice; forced attachment port takes priority
        if (attach_port_force) begin
            next_aui_select = 1'b1;
            next_tp_select  = 1'b0;
        end else if (port_auto_select) begin
            // Auto: pair while its link holds, else attachment port
            next_aui_select = !link_ok;
            next_tp_select  = link_ok;
        end else begin
            next_aui_select = 1'b0;
            next_tp_select  = 1'b1;
        end
        // Pair transmitter needs link pulses or link test disabled
        next_tp_tx_enable = next_tp_select && (link_ok || link_test_disable);
    end

    // Register only
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_data      <= 1'b0;
            aui_select   <= 1'b0;
            tp_select    <= 1'b0;
            tp_tx_enable <= 1'b0;
        end else begin
            rx_data      <= next_rx_data;
            aui_select   <= next_aui_select;
            tp_select    <= next_tp_select;
            tp_tx_enable <= next_tp_tx_enable;
        end
    end

    // ==========================================================
    // Receive frame gating
    // The enable is sampled only at frame start, so clearing it mid
    // frame lets the frame finish; the next one is refused.
    lcp_rx_state_t rx_state;
    lcp_rx_state_t next_rx_state;

    always_comb begin
        next_rx_state = rx_state;
        case (rx_state)
            LCP_RX_IDLE: begin
                if (crs && receive_enable_ctl) begin
                    next_rx_state = LCP_RX_PASS;
                end else if (crs) begin
                    next_rx_state = LCP_RX_DROP;
                end
            end
            LCP_RX_PASS: begin
                // Runs to end of frame whatever the enable does
                if (!crs) begin
                    next_rx_state = LCP_RX_IDLE;
                end
            end
            LCP_RX_DROP: begin
                if (!crs) begin
                    next_rx_state = LCP_RX_IDLE;
                end
            end
            default: begin
                next_rx_state = LCP_RX_IDLE;
            end
        endcase
    end

    // Register only
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_state  <= LCP_RX_IDLE;
            rx_accept <= 1'b0;
        end else begin
            rx_state  <= next_rx_state;
            rx_accept <= (next_rx_state == LCP_RX_PASS);
        end
    end

    // ==========================================================
    // Transmit frame gating
    // A started frame runs to tx_done even if the enable drops.
    lcp_tx_state_t tx_state;
    lcp_tx_state_t next_tx_state;

    always_comb begin
        next_tx_state = tx_state;
        case (tx_state)
            LCP_TX_IDLE: begin
                if (tx_request && transmit_enable_ctl) begin
                    next_tx_state = LCP_TX_SEND;
                end
            end
            LCP_TX_SEND: begin
                if (tx_done) begin
                    next_tx_state = LCP_TX_IDLE;
                end
            end
            default: begin
                next_tx_state = LCP_TX_IDLE;
            end
        endcase
    end

    // Register only
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_state  <= LCP_TX_IDLE;
            tx_active <= 1'b0;
        end else begin
            tx_state  <= next_tx_state;
            tx_active <= (next_tx_state == LCP_TX_SEND);
        end
    end

    // ==========================================================
    // MAC option outputs
    logic next_two_part;
    logic next_mod_boff;
    logic next_lo_sql;

    always_comb begin
        next_two_part = !line_config[LCP_CFG_DEF_DIS];
        next_mod_boff = line_config[LCP_CFG_MOD_BOFF];
        next_lo_sql   = line_config[LCP_CFG_LO_SQL];
    end

    // Register only
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            two_part_deferral       <= 1'b0;
            modified_backoff_enable <= 1'b0;
            low_squelch_select      <= 1'b0;
        end else begin
            two_part_deferral       <= next_two_part;
            modified_backoff_enable <= next_mod_boff;
            low_squelch_select      <= next_lo_sql;
        end
    end

    // hsize unused: only whole words are supported
    logic unused_ok;
    assign unused_ok = ^hsize;

endmodule : lcp_line_ctl
`default_nettype wire

// ==== shared/lcp_pkg.sv ====
// Constants for the line control polarity and configuration block.
// Assumes a 32-bit AHB-Lite register window and a single system clock.
package lcp_pkg;

    // ==========================================================
    // Register offsets (byte addresses, one word each)
    localparam logic [11:0] LCP_OFS_LINE_CONFIG = 12'h000;
    localparam logic [11:0] LCP_OFS_LINE_STATE  = 12'h004;
    localparam logic [11:0] LCP_OFS_LINK_CTL    = 12'h008;

    // ==========================================================
    // Line configuration fields
    localparam int LCP_CFG_RX_ON     = 6;
    localparam int LCP_CFG_TX_ON     = 7;
    localparam int LCP_CFG_AUI_ONLY  = 8;
    localparam int LCP_CFG_AUTO_SEL  = 9;
    localparam int LCP_CFG_MOD_BOFF  = 11;
    localparam int LCP_CFG_POL_DIS   = 12;
    localparam int LCP_CFG_DEF_DIS   = 13;
    localparam int LCP_CFG_LO_SQL    = 14;
    // Writable bits; the low six bits are a fixed identifier
    localparam logic [15:0] LCP_CFG_WMASK = 16'h7bc0;
    localparam logic [15:0] LCP_CFG_RESET = 16'h0013;

    // ==========================================================
    // Line state fields
    localparam int LCP_ST_LINK_OK  = 7;
    localparam int LCP_ST_AUI      = 8;
    localparam int LCP_ST_TP       = 9;
    localparam int LCP_ST_POL_OK   = 12;
    localparam int LCP_ST_CRS      = 14;
    localparam logic [15:0] LCP_ST_ID = 16'h0014;

    // ==========================================================
    // Link control register
    localparam int          LCP_LINK_TEST_DIS = 0;
    localparam logic [15:0] LCP_LINK_RESET    = 16'h0000;

    // ==========================================================
    // AHB-Lite transfer types
    localparam logic [1:0] LCP_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] LCP_HTRANS_SEQ    = 2'h3;

endpackage : lcp_pkg

// ==== shared/lcp_pol_if.sv ====
// Carrier between the core and the polarity detector.
// Assumes both ends run on the same system clock.
`timescale 1ns/100ps
`default_nettype none
interface lcp_pol_if;
    logic pulse_pos;   // Positive-going link pulse seen
    logic pulse_neg;   // Negative-going link pulse seen
    logic reversed;    // Detected polarity is reversed

    // Detector end
    modport det (input pulse_pos, input pulse_neg, output reversed);
    // Core end
    modport core (output pulse_pos, output pulse_neg, input reversed);
endinterface : lcp_pol_if
`default_nettype wire

// ==== core/lcp_pol_detect.sv ====
// Receive polarity detector for the twisted-pair input.
// Assumes pulse indications are synchronous one-cycle strobes.
`timescale 1ns/100ps
`default_nettype none
module lcp_pol_detect (
    // Clock and reset
    input  wire logic  mclk,
    input  wire logic  sys_rst,
    // Detector side of the carrier
    lcp_pol_if.det     pol
);

    // ==========================================================
    // Polarity state
    logic reversed;       // Current detected polarity
    logic next_reversed;  // Next detected polarity

    // Follows every lone pulse, independent of any configuration
    always_comb begin
        next_reversed = reversed;
        if (pol.pulse_neg && !pol.pulse_pos) begin
            next_reversed = 1'b1;
        end else if (pol.pulse_pos && !pol.pulse_neg) begin
            next_reversed = 1'b0;
        end
    end

    // Register only
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            reversed <= 1'b0;
        end else begin
            reversed <= next_reversed;
        end
    end

    assign pol.reversed = reversed;

endmodule : lcp_pol_detect
`default_nettype wire

// ==== testbench/lcp_line_ctl_monitor.sv ====
// Port checker for the line control core.
// Assumes it is bound into every lcp_line_ctl instance.
`timescale 1ns/100ps
`default_nettype none
module lcp_line_ctl_monitor (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Bus answer
    input wire logic hreadyout,
    input wire logic hresp,
    // Receive line
    input wire logic tp_pulse_pos,
    input wire logic tp_pulse_neg,
    input wire logic tp_rx_data,
    input wire logic rx_data,
    // Frame control
    input wire logic crs,
    input wire logic rx_accept,
    input wire logic tx_request,
    input wire logic tx_done,
    input wire logic tx_active,
    // Port choice
    input wire logic aui_select,
    input wire logic tp_select,
    input wire logic tp_tx_enable,
    input wire logic link_ok
);
    // ==========================================================
    // Polarity mirror, rebuilt from the pulse strobes
    logic rev_h;       // Reversed polarity seen
    logic next_rev_h;  // Next mirror value
    // Lone pulse decides; both or none hold the last verdict
    always_comb begin
        next_rev_h = rev_h;
        if (tp_pulse_neg && !tp_pulse_pos) next_rev_h = 1'b1;
        if (tp_pulse_pos && !tp_pulse_neg) next_rev_h = 1'b0;
    end
    // Mirror register
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) rev_h <= 1'b0;
        else rev_h <= next_rev_h;
    end
    // ==========================================================
    // Properties
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // Carrier was up at the edge that opened a frame
    sequence s_crs_was_up;
        $past(crs);
    endsequence
    // Transmit frame closing at this edge
    sequence s_tx_finish;
        tx_active && tx_done;
    endsequence
    a_ready_out_okay: assert property (!$past(sys_rst) |-> hreadyout && !hresp)
        else $error("bus slave not ready or not okay");
    a_port_exclusive: assert property (!$past(sys_rst) |-> aui_select != tp_select)
        else $error("port choice not exactly one");
    a_tptx_on_tp: assert property (tp_tx_enable |-> tp_select)
        else $error("pair transmitter on while pair not chosen");
    // With link present the pair transmitter must follow the port choice
    a_tptx_with_link: assert property (!$past(sys_rst) && $past(link_ok)
        |-> tp_tx_enable == tp_select) else $error("pair transmitter off despite link");
    a_rx_pass_normal: assert property (!$past(sys_rst) && !$past(rev_h)
        |-> rx_data == $past(tp_rx_data)) else $error("receive data altered");
    a_rx_start_crs: assert property ($rose(rx_accept) |-> s_crs_was_up)
        else $error("frame accepted without carrier");
    a_rx_hold_frame: assert property (rx_accept && crs |=> rx_accept)
        else $error("frame reception cut short");
    a_rx_end_frame: assert property (rx_accept && !crs |=> !rx_accept)
        else $error("frame acceptance outlives carrier");
    a_tx_start_req: assert property ($rose(tx_active) |-> $past(tx_request))
        else $error("transmit started without request");
    a_tx_hold_frame: assert property (tx_active && !tx_done |=> tx_active)
        else $error("transmit frame cut short");
    a_tx_stop_done: assert property (s_tx_finish |=> !tx_active)
        else $error("transmit not ended by done");
endmodule : lcp_line_ctl_monitor
bind lcp_line_ctl lcp_line_ctl_monitor u_mon (.mclk, .sys_rst, .hreadyout, .hresp,
    .tp_pulse_pos, .tp_pulse_neg, .tp_rx_data, .rx_data, .crs, .rx_accept, .tx_request,
    .tx_done, .tx_active, .aui_select, .tp_select, .tp_tx_enable, .link_ok);
`default_nettype wire

// ==== testbench/lcp_line_model.sv ====
// Twisted-pair far end: link pulses and receive data.
// Assumes the bench commands the wiring and the sent bit.
`timescale 1ns/100ps
`default_nettype none
module lcp_line_model (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic sys_rst,
    // Bench commands
    input  wire logic wire_swap,
    input  wire logic data_bit,
    // Line towards the core
    output var  logic tp_pulse_pos,
    output var  logic tp_pulse_neg,
    output var  logic tp_rx_data
);
    // ==========================================================
    // Pulse spacing; a swapped pair inverts pulses and data alike
    logic [2:0] gap_cnt;  // Cycles since the last link pulse
    assign tp_pulse_pos = (gap_cnt == 3'h0) && !wire_swap;
    assign tp_pulse_neg = (gap_cnt == 3'h0) && wire_swap;
    assign tp_rx_data   = data_bit ^ wire_swap;
    // Free-running gap counter
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) gap_cnt <= 3'h1;
        else gap_cnt <= gap_cnt + 3'h1;
    end
endmodule : lcp_line_model
`default_nettype wire

// ==== testbench/line_control_polarity_config_tb.sv ====
// Bench for the line control core: bus tasks and scenarios.
// Assumes the line model stands in for the cable.
`timescale 1ns/100ps
`default_nettype none
module line_control_polarity_config_tb;
    import lcp_pkg::*;
    // ==========================================================
    // Signals
    logic        mclk, sys_rst, hsel, hwrite, hready, hreadyout, hresp;
    logic [11:0] haddr;
    logic [1:0]  htrans;
    logic [31:0] hwdata, hrdata, rdat;
    logic        ee_present, ee_load_valid, link_ok, crs, tx_request, tx_done;
    logic [15:0] ee_load_data, cfg;
    logic        tp_pulse_pos, tp_pulse_neg, tp_rx_data, rx_data, rx_accept, tx_active;
    logic        aui_select, tp_select, tp_tx_enable, tpd, mbe, lsq, wire_swap, data_bit;
    logic        e_aui;
    int          error_cnt, n_compared, cyc;
    assign hready = hreadyout;
    // ==========================================================
    // Design and far end
    lcp_line_ctl dut (.mclk, .sys_rst, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready, .hreadyout, .hrdata, .hresp, .ee_present,
        .ee_load_valid, .ee_load_data, .tp_pulse_pos, .tp_pulse_neg, .tp_rx_data,
        .link_ok, .rx_data, .crs, .rx_accept, .tx_request, .tx_done, .tx_active,
        .aui_select, .tp_select, .tp_tx_enable, .two_part_deferral(tpd),
        .modified_backoff_enable(mbe), .low_squelch_select(lsq));
    lcp_line_model u_line (.mclk, .sys_rst, .wire_swap, .data_bit, .tp_pulse_pos,
        .tp_pulse_neg, .tp_rx_data);
    always #25 mclk = ~mclk;
    // Hang guard: far above the 150 or so cycles the run needs
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    // ==========================================================
    // Tasks
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("[ERR] %0t exp=%h got=%h", $time, exp, got);
            error_cnt++;
        end
    endtask : chk
    // One single transfer; entered just after a rising edge
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= wr;
        htrans <= LCP_HTRANS_NONSEQ;
        @(posedge mclk);
        while (hready !== 1'b1) @(posedge mclk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge mclk);
        while (hready !== 1'b1) @(posedge mclk);
        rdat = hrdata;
    endtask : bus
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        bus(1'b1, a, {16'h0000, d});
    endtask : wr
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(e, rdat & m);
    endtask : rd_chk
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask : tick
    // ==========================================================
    // Scenarios
    initial begin
        {mclk, hsel, hwrite, ee_present, ee_load_valid, link_ok, crs} = 7'h00;
        {tx_request, tx_done, wire_swap, data_bit, haddr, htrans} = 18'h0;
        {hwdata, ee_load_data, error_cnt, n_compared, cyc} = '0;
        sys_rst = 1'b1;
        tick(12);
        sys_rst <= 1'b0;
        @(posedge mclk);
        rd_chk(LCP_OFS_LINE_CONFIG, 32'hffffffff, {16'h0, LCP_CFG_RESET});
        rd_chk(LCP_OFS_LINE_STATE, 32'h103f, 32'h1014);
        wr(LCP_OFS_LINE_CONFIG, 16'hffff);
        rd_chk(LCP_OFS_LINE_CONFIG, 32'hffffffff, {16'h0, LCP_CFG_WMASK | LCP_CFG_RESET});
        rd_chk(12'h00c, 32'hffffffff, 32'h0);
        // Every port mode, with and without link, plus option bits
        for (int i = 0; i < 8; i++) begin
            cfg = {1'b0, i[2], i[1], 1'b0, i[0], 1'b0, i[1:0], 8'h00};
            e_aui = i[0] | (i[1] & !i[2]);
            link_ok <= i[2];
            wr(LCP_OFS_LINE_CONFIG, cfg);
            tick(3);
            chk({e_aui, !e_aui, !e_aui & i[2]}, {aui_select, tp_select, tp_tx_enable});
            chk({!i[1], i[0], i[2]}, {tpd, mbe, lsq});
        end
        // Test-disable lets the pair transmitter run without link
        link_ok <= 1'b0;
        wr(LCP_OFS_LINE_CONFIG, 16'h0000);
        wr(LCP_OFS_LINK_CTL, 16'h0001);
        tick(3);
        chk(32'h1, {31'h0, tp_tx_enable});
        wr(LCP_OFS_LINK_CTL, 16'h0000);
        // Reversed pair: flag clear, data corrected, then left raw
        wire_swap <= 1'b1;
        data_bit  <= 1'b1;
        tick(12);
        rd_chk(LCP_OFS_LINE_STATE, 32'h103f, 32'h0014);
        chk(32'h1, {31'h0, rx_data});
        wr(LCP_OFS_LINE_CONFIG, 16'h1000);
        tick(3);
        chk(32'h0, {31'h0, rx_data});
        rd_chk(LCP_OFS_LINE_STATE, 32'h103f, 32'h0014);
        wire_swap <= 1'b0;
        tick(12);
        rd_chk(LCP_OFS_LINE_STATE, 32'h103f, 32'h1014);
        chk(32'h1, {31'h0, rx_data});
        // Receive off mid-frame: frame finishes, next one refused
        wr(LCP_OFS_LINE_CONFIG, 16'h0040);
        crs <= 1'b1;
        tick(3);
        wr(LCP_OFS_LINE_CONFIG, 16'h0000);
        chk(32'h1, {31'h0, rx_accept});
        crs <= 1'b0;
        tick(3);
        crs <= 1'b1;
        tick(3);
        chk(32'h0, {31'h0, rx_accept});
        crs <= 1'b0;
        // Transmit off mid-frame: frame finishes, next one refused
        wr(LCP_OFS_LINE_CONFIG, 16'h0080);
        tx_request <= 1'b1;
        tick(3);
        wr(LCP_OFS_LINE_CONFIG, 16'h0000);
        chk(32'h1, {31'h0, tx_active});
        tx_done <= 1'b1;
        tick(1);
        tx_done <= 1'b0;
        tick(3);
        chk(32'h0, {31'h0, tx_active});
        tx_request <= 1'b0;
        // Second reset with a configuration memory present
        sys_rst    <= 1'b1;
        ee_present <= 1'b1;
        tick(12);
        sys_rst <= 1'b0;
        tick(1);
        ee_load_data  <= 16'hffff;
        ee_load_valid <= 1'b1;
        tick(1);
        ee_load_valid <= 1'b0;
        rd_chk(LCP_OFS_LINE_CONFIG, 32'hffffffff, {16'h0, LCP_CFG_WMASK | LCP_CFG_RESET});
        tally_and_finish();
    end
endmodule : line_control_polarity_config_tb
`default_nettype wire
